// *** verilog/hpx_consts.svh ***
// Offsets, field positions, reset values and timing constants of the hot-plug expander controller
`ifndef HPX_CONSTS_SVH
`define HPX_CONSTS_SVH

`define HPX_CLK_NS 4
`define HPX_SAMPLE_MS 40
`define HPX_NS_PER_MS 1000000

`define HPX_OFF_SWCTL 8'h00
`define HPX_OFF_SMBSTS 8'h04
`define HPX_OFF_EXPIF 8'h08
`define HPX_OFF_CTL_B 8'h0C
`define HPX_OFF_CTL_C 8'h10
`define HPX_OFF_STS_B 8'h14
`define HPX_OFF_STS_C 8'h18
`define HPX_OFF_UPCTL 8'h1C

`define HPX_SW_REV 0
`define HPX_SMB_ADDR 23:17
`define HPX_SMB_ERR 24
`define HPX_IF_SIG 15:0
`define HPX_IF_RELOAD 16
`define HPX_IF_TEST 17
`define HPX_SC_MASK 4:0
`define HPX_SC_SLOT_IRQ_MASTER_ON 5
`define HPX_SC_AIC 7:6
`define HPX_SC_PIC 9:8
`define HPX_SC_PWR 10
`define HPX_SC_LOCK 11
`define HPX_SC_EN 12
`define HPX_SC_D3 13
`define HPX_SC_MSI 14
`define HPX_SC_INTXOFF 15
`define HPX_UP_BTNCAP 0
`define HPX_UP_ALTFN 1

`define HPX_FL_ABP 0
`define HPX_FL_PFD 1
`define HPX_FL_MRL 2
`define HPX_FL_PDC 3
`define HPX_FL_CC 4

`define HPX_SC_RST 16'h0000
`define HPX_SIG_RST 16'h3F3F
`define HPX_OUT_NEGATED 4'h3
`define HPX_IND_OFF 2'h3
`define HPX_IND_ON 2'h1
`define HPX_IND_BLINK 2'h2

`define HPX_CFG_OUTREG_VAL 8'h50
`define HPX_CFG_POL_VAL 8'h00
`define HPX_CFG_DIR_VAL 8'h0F

`endif

// *** verilog/hpx_pkg.sv ***
// Types shared by the hot-plug expander controller
package hpx_pkg;
  typedef enum logic [1:0] {PORT_A = 2'h0, PORT_B = 2'h1, PORT_C = 2'h2} hpx_port_t;
  typedef enum logic [2:0] {
    ATTN_ON = 3'h0, ATTN_BLINK = 3'h1, ATTN_OFF = 3'h2,
    PWR_ON = 3'h3, PWR_BLINK = 3'h4, PWR_OFF = 3'h5, BUTTON_PRESSED = 3'h6
  } hpx_code_t;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_ISSUE = 3'h2, ST_WAIT = 3'h4} hpx_state_t;
  typedef struct packed {
    logic wr;
    logic [6:0] dev;
    logic [7:0] idx;
    logic [7:0] data;
  } hpx_smb_req_t;
  typedef struct packed {
    logic valid;
    hpx_port_t port;
    hpx_code_t code;
  } hpx_msg_t;
endpackage

// *** verilog/hpx_ctrl.sv ***
// Hot-plug controller for ports A, B and C driving a 16-bit SMBus I/O expander
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "hpx_consts.svh"
// Notes on behaviour
// RQ1 - Interlock outputs stay negated unless revision-select is set.
// RQ2 - Expander bits 0-3 port B inputs, 4-7 outputs; 8-15 same for C.
// RQ3 - Software loads the expander bus address during configuration.
// RQ4 - Changing the expander address starts the configuration writes.
// RQ5 - Disabled downstream ports drive all hot-plug outputs negated.
// RQ6 - Config writes 0x50 to regs 2,3, 0x0 to 4,5, 0x0F to 6,7, reads 0,1.
// RQ7 - Output changes write port B to register 2, port C to register 3.
// RQ8 - Expander interrupt pin asserted starts an input read.
// RQ9 - Input reads spaced at least 40 ms apart.
// RQ10 - Upstream button sampled no more often than every 40 ms.
// RQ11 - Port B inputs from register 0, port C inputs from register 1.
// RQ12 - Expander transaction errors recorded in the SMBus status register.
// RQ13 - Signal fields show current expander inputs and outputs.
// RQ14 - Reload bit rewrites outputs and rereads inputs.
// RQ15 - Test mode: field writes drive expander outputs, controllers blocked.
// RQ16 - Revision-select set: ports B, C send no messages, drop received ones.
// RQ17 - Revision-select clear: ports B, C send and process messages.
// RQ18 - Indicator field change on enabled port sends ON, BLINK or OFF message.
// RQ19 - Button message on enabled port sets button flag, never forwarded.
// RQ20 - Slot flags interrupt if unmasked and enabled; MSI or INTx chosen.
// RQ21 - D3hot unmasked event sends PME; command completion never wakes.
// RQ22 - Upstream port drops and sends no messages with revision-select set.
// RQ23 - Expander address is 7 bits at 23:17, reset zero, writable.
// RQ24 - Sampled upstream button press sends button message upstream.
// RQ25 - New input values compared with old set slot change flags.
module hpx_ctrl
  import hpx_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = (`HPX_SAMPLE_MS * `HPX_NS_PER_MS) / `HPX_CLK_NS
) (
  input wire logic clock_i, // Core clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic [7:0] addr_i, // Register byte address
  input wire logic [31:0] wdata_i, // Register write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [31:0] rdata_o, // Read data, cycle after strobe
  output hpx_smb_req_t smb_req_o, // Request to SMBus master engine
  output logic smb_valid_o, // Request valid until done
  input wire logic smb_done_i, // Engine finished request
  input wire logic smb_err_i, // Engine error, with done
  input wire logic [7:0] smb_rdata_i, // Engine read byte, with done
  input wire logic expander_irq_n_i, // Expander interrupt pin, active low
  input wire logic upstream_button_n_i, // Upstream button pin, active low
  input wire hpx_msg_t msg_rx_i, // Received hot-plug message
  output hpx_msg_t msg_tx_o, // Hot-plug message to send
  input wire logic msg_tx_ready_i, // Message sink accepts
  output logic [1:0] intx_o, // Legacy interrupt level, B and C
  output logic [1:0] msi_o, // MSI request pulse, B and C
  output logic [1:0] pme_o, // PM_PME request pulse, B and C
  output logic [1:0] upstream_attn_led_o, // Upstream attention indicator state
  output logic [1:0] upstream_power_led_o // Upstream power indicator state
);
  if (SAMPLE_CYCLES < 2 || SAMPLE_CYCLES >= (1 << 24)) begin : g_chk
    $error("SAMPLE_CYCLES out of range");
  end

  localparam logic [23:0] SAMPLE_LAST = 24'(SAMPLE_CYCLES - 1);

  logic rev_r;
  logic [6:0] ioe_addr_r;
  logic smb_err_r;
  logic test_r;
  logic [15:0] sig_r;
  logic [1:0][15:0] ctl_r;
  logic [1:0][4:0] flags_r;
  logic [1:0] up_ctl_r;
  logic irq_s1_r, irq_s2_r, btn_s1_r, btn_s2_r, btn_smp_r;
  logic cfg_pend_r, out_pend_r, rd_pend_r, cfg_job_r;
  logic [2:0] step_r, last_r;
  hpx_state_t st_r;
  logic [23:0] gap_r, samp_r;
  logic [4:0] mpend_r;

  function automatic logic [7:0] ctl_off(input int p);
    return (p == 0) ? `HPX_OFF_CTL_B : `HPX_OFF_CTL_C;
  endfunction

  function automatic logic [3:0] out_nib(input logic [15:0] ctl, input logic rev);
    logic [3:0] n;
    n = `HPX_OUT_NEGATED;
    if (ctl[`HPX_SC_EN]) begin
      n[0] = (ctl[`HPX_SC_AIC] == `HPX_IND_OFF);
      n[1] = (ctl[`HPX_SC_PIC] == `HPX_IND_OFF);
      n[2] = ctl[`HPX_SC_PWR];
      n[3] = ctl[`HPX_SC_LOCK] & rev;
    end
    return n;
  endfunction

  function automatic hpx_code_t ind_code(input logic [1:0] f, input logic pwr);
    hpx_code_t c;
    case (f)
      `HPX_IND_ON: c = pwr ? PWR_ON : ATTN_ON;
      `HPX_IND_BLINK: c = pwr ? PWR_BLINK : ATTN_BLINK;
      default: c = pwr ? PWR_OFF : ATTN_OFF;
    endcase
    return c;
  endfunction

  function automatic logic [7:0] op_reg(input logic [2:0] s);
    logic [7:0] r;
    case (s)
      3'h6: r = 8'h00;
      3'h7: r = 8'h01;
      default: r = {5'h00, s} + 8'h02;
    endcase
    return r;
  endfunction

  // Combinational strobes
  logic sw_wr, smb_wr, if_wr, addr_chg, reload, done, op_rd;
  logic [3:0] nib_b, nib_c;
  logic [1:0] ctl_wr, sts_wr, cap, rx_btn;
  logic [1:0][4:0] set_v;
  logic out_job_end, cfg_job_end, press;
  assign sw_wr = ce_i && wr_i && addr_i == `HPX_OFF_SWCTL;
  assign smb_wr = ce_i && wr_i && addr_i == `HPX_OFF_SMBSTS;
  assign if_wr = ce_i && wr_i && addr_i == `HPX_OFF_EXPIF;
  assign addr_chg = smb_wr && wdata_i[`HPX_SMB_ADDR] != ioe_addr_r;
  assign reload = if_wr && wdata_i[`HPX_IF_RELOAD];
  assign nib_b = out_nib(ctl_r[0], rev_r);
  assign nib_c = out_nib(ctl_r[1], rev_r);
  assign done = ce_i && st_r == ST_WAIT && smb_done_i;
  assign op_rd = step_r[2] & step_r[1];
  assign out_job_end = done && !cfg_job_r && !op_rd && step_r == last_r;
  assign cfg_job_end = done && cfg_job_r && step_r == last_r;
  assign press = ce_i && samp_r == SAMPLE_LAST && btn_smp_r && !btn_s2_r;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      ctl_wr[p] = ce_i && wr_i && addr_i == ctl_off(p);
      sts_wr[p] = ce_i && wr_i && addr_i == (p == 0 ? `HPX_OFF_STS_B : `HPX_OFF_STS_C);
      cap[p] = done && !smb_err_i && step_r == (p == 0 ? 3'h6 : 3'h7);
      rx_btn[p] = ce_i && msg_rx_i.valid && !rev_r && msg_rx_i.code == BUTTON_PRESSED &&
                  msg_rx_i.port == (p == 0 ? PORT_B : PORT_C); // [RQ16] [RQ17]
    end
    for (int p = 0; p < 2; p++) begin
      set_v[p] = '0;
      set_v[p][`HPX_FL_ABP] = rx_btn[p] | (cap[p] & sig_r[8*p] & ~smb_rdata_i[0]); // [RQ19]
      set_v[p][`HPX_FL_PFD] = cap[p] & sig_r[8*p+2] & ~smb_rdata_i[2]; // [RQ25]
      set_v[p][`HPX_FL_MRL] = cap[p] & (sig_r[8*p+3] ^ smb_rdata_i[3]);
      set_v[p][`HPX_FL_PDC] = cap[p] & (sig_r[8*p+1] ^ smb_rdata_i[1]);
      set_v[p][`HPX_FL_CC] = out_job_end;
      if (!ctl_r[p][`HPX_SC_EN]) set_v[p] = '0;
    end
  end

  // Two-flop synchronisers for pins
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {irq_s1_r, irq_s2_r, btn_s1_r, btn_s2_r} <= 4'hF;
    end else if (ce_i) begin
      irq_s1_r <= expander_irq_n_i;
      irq_s2_r <= irq_s1_r;
      btn_s1_r <= upstream_button_n_i;
      btn_s2_r <= btn_s1_r;
    end
  end

  // Software registers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rev_r <= 1'b0;
      ioe_addr_r <= 7'h00;
      test_r <= 1'b0;
      up_ctl_r <= 2'h0;
      ctl_r <= {2{`HPX_SC_RST}};
    end else begin
      if (sw_wr) rev_r <= wdata_i[`HPX_SW_REV];
      if (smb_wr) ioe_addr_r <= wdata_i[`HPX_SMB_ADDR]; // [RQ23]
      if (if_wr) test_r <= wdata_i[`HPX_IF_TEST];
      if (ce_i && wr_i && addr_i == `HPX_OFF_UPCTL) up_ctl_r <= wdata_i[1:0];
      for (int p = 0; p < 2; p++) begin
        if (ctl_wr[p]) ctl_r[p] <= wdata_i[15:0];
      end
    end
  end

  // Error flag, set wins over write-one-to-clear
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) smb_err_r <= 1'b0;
    else smb_err_r <= (smb_err_r & ~(smb_wr & wdata_i[`HPX_SMB_ERR])) | (done & smb_err_i); // [RQ12]
  end

  // Slot status flags, set wins over clear
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_r <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        flags_r[p] <= (flags_r[p] & ~(sts_wr[p] ? wdata_i[4:0] : 5'h00)) | set_v[p]; // [RQ25]
      end
    end
  end

  // Signal field: outputs follow controllers unless in test mode
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sig_r <= `HPX_SIG_RST;
    end else if (ce_i) begin
      if (test_r) begin
        if (if_wr) begin
          sig_r[7:4] <= wdata_i[7:4]; // [RQ15]
          sig_r[15:12] <= wdata_i[15:12];
        end
      end else begin
        sig_r[7:4] <= nib_b; // [RQ1] [RQ5] [RQ13]
        sig_r[15:12] <= nib_c;
      end
      if (cap[0]) sig_r[3:0] <= smb_rdata_i[3:0]; // [RQ11] [RQ2]
      if (cap[1]) sig_r[11:8] <= smb_rdata_i[3:0];
    end
  end

  // Pending expander jobs
  logic out_set;
  assign out_set = reload || cfg_job_end ||
                   (ce_i && !test_r && {nib_c, nib_b} != {sig_r[15:12], sig_r[7:4]}) || // [RQ7]
                   (if_wr && test_r && {wdata_i[15:12], wdata_i[7:4]} != {sig_r[15:12], sig_r[7:4]}); // [RQ15]
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_pend_r <= 1'b0;
      out_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else if (ce_i) begin
      cfg_pend_r <= (cfg_pend_r && !(st_r == ST_IDLE)) || addr_chg; // [RQ4]
      out_pend_r <= (out_pend_r && !(st_r == ST_IDLE && !cfg_pend_r)) || out_set; // [RQ14]
      rd_pend_r <= (rd_pend_r && !(st_r == ST_IDLE && !cfg_pend_r && !out_pend_r && gap_r == 24'h00_0000)) ||
                   (!irq_s2_r && st_r == ST_IDLE) || reload; // [RQ8] [RQ14]
    end
  end

  // Read spacing and button sampling timers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_r <= 24'h00_0000;
    end else if (ce_i) begin
      if (st_r == ST_ISSUE && step_r == 3'h6 && gap_r == 24'h00_0000) gap_r <= SAMPLE_LAST; // [RQ9]
      else if (gap_r != 24'h00_0000) gap_r <= gap_r - 24'h00_0001;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      samp_r <= 24'h00_0000;
      btn_smp_r <= 1'b1;
    end else if (ce_i) begin
      samp_r <= (samp_r == SAMPLE_LAST) ? 24'h00_0000 : samp_r + 24'h00_0001;
      if (samp_r == SAMPLE_LAST) btn_smp_r <= btn_s2_r; // [RQ10]
    end
  end

  // Expander transaction sequencer
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= ST_IDLE;
      step_r <= 3'h0;
      last_r <= 3'h0;
      cfg_job_r <= 1'b0;
      smb_valid_o <= 1'b0;
      smb_req_o <= '0;
    end else if (ce_i) begin
      unique case (st_r)
        ST_IDLE: begin
          if (cfg_pend_r) begin
            {cfg_job_r, step_r, last_r, st_r} <= {1'b1, 3'h0, 3'h7, ST_ISSUE}; // [RQ6]
          end else if (out_pend_r) begin
            {cfg_job_r, step_r, last_r, st_r} <= {1'b0, 3'h0, 3'h1, ST_ISSUE};
          end else if (rd_pend_r && gap_r == 24'h00_0000) begin
            {cfg_job_r, step_r, last_r, st_r} <= {1'b0, 3'h6, 3'h7, ST_ISSUE};
          end
        end
        ST_ISSUE: begin
          if (!(step_r == 3'h6 && gap_r != 24'h00_0000)) begin // [RQ9]
            smb_valid_o <= 1'b1;
            smb_req_o.wr <= !op_rd;
            smb_req_o.dev <= ioe_addr_r;
            smb_req_o.idx <= op_reg(step_r); // [RQ6] [RQ7] [RQ11]
            if (cfg_job_r) begin
              smb_req_o.data <= (step_r < 3'h2) ? `HPX_CFG_OUTREG_VAL :
                                (step_r < 3'h4) ? `HPX_CFG_POL_VAL : `HPX_CFG_DIR_VAL;
            end else begin
              smb_req_o.data <= step_r[0] ? sig_r[15:8] : sig_r[7:0];
            end
            st_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (smb_done_i) begin
            smb_valid_o <= 1'b0;
            if (step_r == last_r) begin
              st_r <= ST_IDLE;
            end else begin
              step_r <= step_r + 3'h1;
              st_r <= ST_ISSUE;
            end
          end
        end
      endcase
    end
  end

  // Interrupt and wake-up requests
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      intx_o <= 2'h0;
      msi_o <= 2'h0;
      pme_o <= 2'h0;
    end else if (ce_i) begin
      for (int p = 0; p < 2; p++) begin
        intx_o[p] <= ctl_r[p][`HPX_SC_SLOT_IRQ_MASTER_ON] && !ctl_r[p][`HPX_SC_MSI] && !ctl_r[p][`HPX_SC_INTXOFF] &&
                     |(flags_r[p] & ctl_r[p][`HPX_SC_MASK]); // [RQ20]
        msi_o[p] <= ctl_r[p][`HPX_SC_SLOT_IRQ_MASTER_ON] && ctl_r[p][`HPX_SC_MSI] &&
                    |(set_v[p] & ~flags_r[p] & ctl_r[p][`HPX_SC_MASK]); // [RQ20]
        pme_o[p] <= ctl_r[p][`HPX_SC_D3] &&
                    |(set_v[p] & ~flags_r[p] & ctl_r[p][`HPX_SC_MASK] & 5'h0F); // [RQ21]
      end
    end
  end

  // Outgoing messages: pending bits B attn, B power, C attn, C power, A button
  logic [4:0] mset;
  logic [4:0] mpick;
  always_comb begin
    mset = 5'h00;
    for (int p = 0; p < 2; p++) begin
      mset[2*p] = ctl_wr[p] && !rev_r && wdata_i[`HPX_SC_EN] && wdata_i[`HPX_SC_AIC] != 2'h0 &&
                  wdata_i[`HPX_SC_AIC] != ctl_r[p][`HPX_SC_AIC]; // [RQ18] [RQ16]
      mset[2*p+1] = ctl_wr[p] && !rev_r && wdata_i[`HPX_SC_EN] && wdata_i[`HPX_SC_PIC] != 2'h0 &&
                    wdata_i[`HPX_SC_PIC] != ctl_r[p][`HPX_SC_PIC]; // [RQ18]
    end
    mset[4] = press && !rev_r && up_ctl_r[`HPX_UP_BTNCAP] && up_ctl_r[`HPX_UP_ALTFN]; // [RQ24] [RQ22]
    mpick = 5'h00;
    for (int i = 4; i >= 0; i--) begin
      if (mpend_r[i]) mpick = 5'h01 << i;
    end
  end

  logic tx_free;
  assign tx_free = !msg_tx_o.valid || msg_tx_ready_i;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mpend_r <= 5'h00;
      msg_tx_o <= '0;
    end else if (ce_i) begin
      mpend_r <= (mpend_r & ~(tx_free ? mpick : 5'h00)) | mset;
      if (tx_free) begin
        msg_tx_o.valid <= |mpick;
        msg_tx_o.port <= mpick[4] ? PORT_A : (|mpick[1:0] ? PORT_B : PORT_C);
        msg_tx_o.code <= mpick[4] ? BUTTON_PRESSED :
                         mpick[0] ? ind_code(ctl_r[0][`HPX_SC_AIC], 1'b0) :
                         mpick[1] ? ind_code(ctl_r[0][`HPX_SC_PIC], 1'b1) :
                         mpick[2] ? ind_code(ctl_r[1][`HPX_SC_AIC], 1'b0) :
                         ind_code(ctl_r[1][`HPX_SC_PIC], 1'b1);
      end
    end
  end

  // Upstream indicators driven by received messages
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upstream_attn_led_o <= `HPX_IND_OFF;
      upstream_power_led_o <= `HPX_IND_OFF;
    end else if (ce_i && msg_rx_i.valid && msg_rx_i.port == PORT_A && !rev_r) begin // [RQ22]
      case (msg_rx_i.code)
        ATTN_ON: upstream_attn_led_o <= `HPX_IND_ON;
        ATTN_BLINK: upstream_attn_led_o <= `HPX_IND_BLINK;
        ATTN_OFF: upstream_attn_led_o <= `HPX_IND_OFF;
        PWR_ON: upstream_power_led_o <= `HPX_IND_ON;
        PWR_BLINK: upstream_power_led_o <= `HPX_IND_BLINK;
        PWR_OFF: upstream_power_led_o <= `HPX_IND_OFF;
        default: ;
      endcase
    end
  end

  // Register read port
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          `HPX_OFF_SWCTL: rdata_o[`HPX_SW_REV] <= rev_r;
          `HPX_OFF_SMBSTS: rdata_o <= {7'h00, smb_err_r, ioe_addr_r, 17'h0_0000};
          `HPX_OFF_EXPIF: rdata_o <= {14'h0000, test_r, 1'b0, sig_r}; // [RQ13]
          `HPX_OFF_CTL_B: rdata_o[15:0] <= ctl_r[0];
          `HPX_OFF_CTL_C: rdata_o[15:0] <= ctl_r[1];
          `HPX_OFF_STS_B: rdata_o[4:0] <= flags_r[0];
          `HPX_OFF_STS_C: rdata_o[4:0] <= flags_r[1];
          `HPX_OFF_UPCTL: rdata_o[1:0] <= up_ctl_r;
          default: ;
        endcase
      end
    end
  end

  // Checks
  logic [24:0] rd_age_r;
  logic rd_seen_r;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_age_r <= 25'h000_0000;
      rd_seen_r <= 1'b0;
    end else if (ce_i) begin
      if (st_r == ST_ISSUE && step_r == 3'h6 && gap_r == 24'h00_0000) begin
        rd_age_r <= 25'h000_0000;
        rd_seen_r <= 1'b1;
      end else if (!rd_age_r[24]) begin
        rd_age_r <= rd_age_r + 25'h000_0001;
      end
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_addr_wr;
    smb_wr && wdata_i[`HPX_SMB_ADDR] != ioe_addr_r;
  endsequence
  sequence s_read_issue;
    st_r == ST_ISSUE && step_r == 3'h6 && gap_r == 24'h00_0000 && ce_i;
  endsequence

  AST_LOCK_OLD: assert property ((!rev_r && !test_r && ce_i)[*2] |-> !sig_r[7] && !sig_r[15]) // [RQ1]
    else $error("interlock driven in older revision mode");
  AST_CFG_START: assert property (s_addr_wr |=> cfg_pend_r || (st_r == ST_ISSUE && cfg_job_r)) // [RQ4]
    else $error("address change did not start configuration");
  AST_CFG_DATA: assert property (smb_valid_o && cfg_job_r && smb_req_o.idx == 8'h02 |->
                                 smb_req_o.wr && smb_req_o.data == 8'h50) // [RQ6]
    else $error("wrong configuration value for register 2");
  AST_OUT_REG: assert property (smb_valid_o && !cfg_job_r && smb_req_o.wr |->
                                smb_req_o.idx == 8'h02 || smb_req_o.idx == 8'h03) // [RQ7]
    else $error("output write to wrong register");
  AST_RD_GAP: assert property (s_read_issue |-> !rd_seen_r || rd_age_r >= 25'(SAMPLE_CYCLES - 1)) // [RQ9]
    else $error("input reads too close together");
  AST_RD_REG: assert property (smb_valid_o && !smb_req_o.wr |-> smb_req_o.idx == 8'h00 || smb_req_o.idx == 8'h01) // [RQ11]
    else $error("input read from wrong register");
  AST_ERR: assert property (st_r == ST_WAIT && smb_done_i && smb_err_i && ce_i |=> smb_err_r) // [RQ12]
    else $error("transaction error not recorded");
  AST_DISABLED: assert property ((!ctl_r[0][`HPX_SC_EN] && !test_r && ce_i)[*2] |-> sig_r[7:4] == 4'h3) // [RQ5]
    else $error("disabled port outputs not negated");
  AST_INTX: assert property (intx_o[0] |-> $past(ctl_r[0][`HPX_SC_SLOT_IRQ_MASTER_ON])) // [RQ20]
    else $error("interrupt without enable");
  AST_NO_CC_WAKE: assert property (ce_i && ctl_r[0][`HPX_SC_D3] && set_v[0] == 5'h10 |=> !pme_o[0]) // [RQ21]
    else $error("command completion caused wake-up");
endmodule
`default_nettype wire

// *** verification/hpx_smb_model.sv ***
// SMBus engine model with a 16-bit expander behind it
`timescale 1ns/100ps
`default_nettype none
module hpx_smb_model
  import hpx_pkg::*;
(
  input wire logic clock_i, // Core clock
  input wire logic rstn_i, // Reset
  input wire hpx_smb_req_t req_i, // Request
  input wire logic valid_i, // Request valid
  input wire logic [15:0] pins_i, // Pin levels
  input wire logic err_i, // Fail transfers
  input wire logic slow_i, // Slow answers
  output logic done_o, // Done pulse
  output logic err_o, // Error with done
  output logic [7:0] rdata_o // Byte with done
);
  hpx_smb_req_t log_q[$];
  int rd0_at[$];
  int cyc;
  logic [1:0] cnt;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 2'h0;
      done_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 8'h00;
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      done_o <= 1'b0;
      rdata_o <= ~rdata_o;
      cnt <= (valid_i && !done_o) ? cnt + 2'h1 : 2'h0;
      if (valid_i && !done_o && cnt == {slow_i, slow_i}) begin
        done_o <= 1'b1;
        err_o <= err_i;
        log_q.push_back(req_i);
        rdata_o <= req_i.idx[0] ? pins_i[15:8] : pins_i[7:0];
        if (!req_i.wr && req_i.idx == 8'h00) rd0_at.push_back(cyc);
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/hpx_ctrl_tb.sv ***
// Self-checking bench for the hot-plug expander controller
`timescale 1ns/100ps
`default_nettype none
module hpx_ctrl_tb;
  import hpx_pkg::*;
  localparam int SC = 50;
  localparam logic [7:0] IDX [10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h00, 8'h01, 8'h02, 8'h03};
  localparam logic [7:0] DAT [10] = '{8'h50, 8'h50, 8'h00, 8'h00, 8'h0F, 8'h0F, 8'h00, 8'h00, 8'h3A, 8'h35};
  localparam logic [71:0] ROWS [4] = '{{8'h1C, 32'h0000_0003, 32'h0000_0003},
    {8'h20, 32'hFFFF_FFFF, 32'h0000_0000}, {8'h00, 32'h0000_0001, 32'h0000_0001}, {8'h00, 32'h0, 32'h0}};
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic irq_n = 1'b1;
  logic btn_n = 1'b1;
  logic ready = 1'b1;
  logic err_inj = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  logic [15:0] pins = 16'h050A;
  hpx_msg_t rx = '0;
  hpx_msg_t tx;
  hpx_smb_req_t req, lg;
  logic valid, done, err;
  logic [7:0] smb_rd;
  logic [31:0] rdata, v;
  logic [1:0] intx, uattn, upwr;
  int n_errors = 0;
  int comparisons = 0;
  hpx_ctrl #(.SAMPLE_CYCLES(SC)) i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .smb_req_o(req), .smb_valid_o(valid),
    .smb_done_i(done), .smb_err_i(err), .smb_rdata_i(smb_rd), .expander_irq_n_i(irq_n),
    .upstream_button_n_i(btn_n), .msg_rx_i(rx), .msg_tx_o(tx), .msg_tx_ready_i(ready), .intx_o(intx),
    .msi_o(), .pme_o(), .upstream_attn_led_o(uattn), .upstream_power_led_o(upwr));
  hpx_smb_model i_exp (.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req), .valid_i(valid), .pins_i(pins),
    .err_i(err_inj), .slow_i(slow), .done_o(done), .err_o(err), .rdata_o(smb_rd));
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wl(input int n);
    for (int i = 0; i < 3000 && i_exp.log_q.size() < n; i++) @(posedge clock_i);
    #1 chk(32'(i_exp.log_q.size() >= n), 32'h1);
  endtask
  task automatic wm(input int lim);
    for (int i = 0; i < lim && tx.valid !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #60000;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(8'h08);
    chk(v, 32'h0000_3F3F);
    rd(8'h04);
    chk(v, 32'h0);
    foreach (ROWS[i]) begin
      wr(ROWS[i][71:64], ROWS[i][63:32]);
      rd(ROWS[i][71:64]);
      chk(v, ROWS[i][31:0]);
    end
    ce <= 1'b0;
    wr(8'h1C, 32'h0000_0000);
    ce <= 1'b1;
    rd(8'h1C);
    chk(v, 32'h0000_0003);
    $display("reset and registers done");
    wr(8'h04, 32'h0054_0000);
    wl(10);
    for (int i = 0; i < 10; i++) begin
      lg = i_exp.log_q[i];
      chk(32'({lg.wr, lg.dev, lg.idx, (i == 6 || i == 7) ? 8'h00 : lg.data}),
        32'({(i < 6 || i > 7), 7'h2A, IDX[i], DAT[i]}));
    end
    rd(8'h08);
    chk(v, 32'h0000_353A);
    ready <= 1'b0;
    wr(8'h0C, 32'h0000_3870);
    wm(10);
    chk(32'({tx.valid, tx.port, tx.code}), 32'({1'b1, PORT_B, ATTN_ON}));
    repeat (4) @(posedge clock_i);
    #1 chk(32'(tx.valid), 32'h1);
    ready <= 1'b1;
    wl(12);
    chk(32'({i_exp.log_q[10].idx, i_exp.log_q[10].data[7]}), 32'h0000_0004);
    repeat (4) @(posedge clock_i);
    #1 chk(32'(intx), 32'h1);
    rd(8'h14);
    chk(32'(v[4]), 32'h1);
    wr(8'h14, 32'h0000_001F);
    repeat (2) @(posedge clock_i);
    #1 chk(32'(intx), 32'h0);
    wr(8'h00, 32'h0000_0001);
    wr(8'h10, 32'h0000_1840);
    btn_n <= 1'b0;
    wm(150);
    chk(32'(tx.valid), 32'h0);
    wl(14);
    chk(32'({i_exp.log_q[13].idx, i_exp.log_q[13].data[7]}), 32'h0000_0007);
    btn_n <= 1'b1;
    wr(8'h00, 32'h0);
    repeat (120) @(posedge clock_i);
    btn_n <= 1'b0;
    wm(150);
    chk(32'({tx.valid, tx.port, tx.code}), 32'({1'b1, PORT_A, BUTTON_PRESSED}));
    btn_n <= 1'b1;
    $display("messages done");
    slow <= 1'b1;
    pins <= 16'h0500;
    irq_n <= 1'b0;
    wl(21);
    irq_n <= 1'b1;
    wl(22);
    chk(32'(i_exp.rd0_at[2] - i_exp.rd0_at[1] inside {[SC:SC + 30]}), 32'h1);
    rd(8'h08);
    chk(32'(v[3:0]), 32'h0);
    rd(8'h14);
    chk(32'(v[3:0]), 32'h0000_000C);
    wr(8'h14, 32'h0000_001F);
    rx <= '{1'b1, PORT_B, BUTTON_PRESSED};
    @(posedge clock_i);
    rx <= '0;
    wm(5);
    chk(32'(tx.valid), 32'h0);
    rd(8'h14);
    chk(32'(v[0]), 32'h1);
    rx <= '{1'b1, PORT_A, PWR_BLINK};
    @(posedge clock_i);
    rx <= '0;
    @(posedge clock_i);
    #1 chk(32'({uattn, upwr}), 32'h0000_000E);
    err_inj <= 1'b1;
    wr(8'h08, 32'h0002_0000);
    wr(8'h08, 32'h0002_A0A0);
    wl(24);
    chk(32'({i_exp.log_q[22].data, i_exp.log_q[23].data}), 32'h0000_A0A5);
    rd(8'h04);
    chk(32'(v[24]), 32'h1);
    err_inj <= 1'b0;
    wr(8'h08, 32'h0003_A0A0);
    wl(28);
    chk(32'({i_exp.log_q[24].idx, i_exp.log_q[27].idx}), 32'h0000_0201);
    $display("expander debug done");
    wrap_up();
  end
endmodule
`default_nettype wire
